/* ipw_power_ctrl.sv */
// Purpose: Idle and power-down sequencer with wake and reset recovery
// Assumes: APB slave, pins and fuses asynchronous, CPU on gated clock
// Notes:   Analog settling and oscillator itself are outside
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
module ipw_power_ctrl #(
   parameter int unsigned SUT_SCALE_DIV = 1
) (
   // Clock and resets
   input  wire logic          i_ref_clk,
   input  wire logic          i_resetn,
   input  wire logic          i_por_n,
   // APB slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   input  wire logic [3:0]    pstrb,
   output logic [31:0]        o_prdata,
   output logic               o_pready,
   output logic               o_pslverr,
   // Pins and fuses (asynchronous)
   input  wire logic          i_ext_irq_zero_pin_n,
   input  wire logic          i_ext_irq_one_pin_n,
   input  wire logic [7:0]    i_general_pin_irq_n,
   input  wire logic          i_ext_reset_pin_n,
   input  wire logic [1:0]    i_sut_fuse,
   input  wire logic          i_crystal_src,
   input  wire logic          i_bod_fuse,
   // Interrupt controller
   input  wire logic          i_irq_pending,
   input  wire logic          i_clk_div_on,
   // Power and clock controls
   output logic               o_cpu_clk_en,
   output logic               o_periph_clk_en,
   output logic               o_periph_div_en,
   output logic               o_adc_div_bypass,
   output logic               o_port_hold,
   output logic               o_wdt_run,
   output logic               o_osc_en,
   output logic               o_bod_en,
   output logic               o_flash_pwr_en,
   output logic               o_ram_retain,
   output logic               o_int_reset,
   output logic               o_wake_irq,
   output logic               o_baud_doubler
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers, two flops before any use
   localparam int NSYNC = 15;
   logic [NSYNC-1:0] s1_reg;
   logic [NSYNC-1:0] s2_reg;
   logic             prev_rst_reg;

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         s1_reg <= '1;
         s2_reg <= '1;
      end
      else
      begin
         s1_reg <= {i_bod_fuse, i_crystal_src, i_sut_fuse,
                    i_ext_reset_pin_n, i_general_pin_irq_n,
                    i_ext_irq_one_pin_n, i_ext_irq_zero_pin_n};
         s2_reg <= s1_reg;
      end
   end

   logic       ex0_n;
   logic       ex1_n;
   logic [7:0] gp_n;
   logic       rst_pin_n;
   logic [2:0] sut_sel;
   logic       bod_fuse;
   assign ex0_n     = s2_reg[0];
   assign ex1_n     = s2_reg[1];
   assign gp_n      = s2_reg[9:2];
   assign rst_pin_n = s2_reg[10];
   assign sut_sel   = {s2_reg[13], s2_reg[12:11]};
   assign bod_fuse  = s2_reg[14];

   ////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0]        pwr_ctrl_reg;
   logic [31:0]       wake_cfg_reg;
   ipw_pkg::ipw_state_t state_reg;
   ipw_pkg::ipw_state_t state_next;
   logic              wake_pin_reg;    // Wake-source flag; never driven or read
   logic [1:0]        short_cnt_reg;
   logic              tmr_start;
   logic              tmr_done;

   // APB decode helper, used for reads and writes
   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      return a == r;
   endfunction

   logic wr_en;
   logic rd_en;
   assign wr_en = psel && penable && pwrite && o_pready;
   assign rd_en = psel && !penable && !pwrite;

   ////////////////////////////////////////////////////////////////////////
   // Wake qualification from enabled, level-triggered pins
   logic ex0_wake;
   logic ex1_wake;
   logic gp_wake;
   logic wake_low;
   assign ex0_wake = wake_cfg_reg[ipw_pkg::EX0_EN_BIT]
                     && !wake_cfg_reg[ipw_pkg::EX0_TT_BIT] && !ex0_n;
   assign ex1_wake = wake_cfg_reg[ipw_pkg::EX1_EN_BIT]
                     && !wake_cfg_reg[ipw_pkg::EX1_TT_BIT] && !ex1_n;
   assign gp_wake  = wake_cfg_reg[ipw_pkg::GP_GRP_BIT] &&
                     |(wake_cfg_reg[ipw_pkg::GP_MASK_LSB +: 8] &
                       wake_cfg_reg[ipw_pkg::GP_LVL_LSB +: 8] & ~gp_n);
   assign wake_low = ex0_wake || ex1_wake || gp_wake;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer next state
   always_comb
   begin
      state_next = state_reg;
      tmr_start  = 1'b0;
      unique case (state_reg)
         ipw_pkg::IPW_RUN:
            if (pwr_ctrl_reg[ipw_pkg::PDOWN_BIT])
               state_next = ipw_pkg::IPW_PDOWN;
            else if (pwr_ctrl_reg[ipw_pkg::IDLE_BIT])
               state_next = ipw_pkg::IPW_IDLE;
         ipw_pkg::IPW_IDLE:
            if (!rst_pin_n)
               state_next = ipw_pkg::IPW_RST_HOLD;
            else if (i_irq_pending)
               state_next = ipw_pkg::IPW_RUN;
         ipw_pkg::IPW_PDOWN:
            if (!rst_pin_n)
            begin
               state_next = ipw_pkg::IPW_RST_TMR;
               tmr_start  = 1'b1;
            end
            else if (wake_low && pwr_ctrl_reg[ipw_pkg::WEXIT_BIT])
               state_next = ipw_pkg::IPW_WAIT_PIN;
            else if (wake_low)
            begin
               state_next = ipw_pkg::IPW_WAIT_TMR;
               tmr_start  = 1'b1;
            end
         ipw_pkg::IPW_WAIT_TMR:
            if (tmr_done)
               state_next = ipw_pkg::IPW_RUN;
         ipw_pkg::IPW_WAIT_PIN:
            if (!wake_low)
               state_next = ipw_pkg::IPW_RUN;
         ipw_pkg::IPW_RST_TMR:
            if (tmr_done)
               state_next = rst_pin_n ? ipw_pkg::IPW_RST_SHORT
                                      : ipw_pkg::IPW_RST_HOLD;
         ipw_pkg::IPW_RST_HOLD:
            if (rst_pin_n)
               state_next = ipw_pkg::IPW_RUN;
         ipw_pkg::IPW_RST_SHORT:
            if (short_cnt_reg == 2'(ipw_pkg::SHORT_RST_CYC - 1))
               state_next = ipw_pkg::IPW_RUN;
      endcase
   end

   // Power-down is left only by the paths above
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
         state_reg <= ipw_pkg::IPW_RUN;
      else
         state_reg <= state_next;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn || state_reg != ipw_pkg::IPW_RST_SHORT)
         short_cnt_reg <= '0;
      else
         short_cnt_reg <= short_cnt_reg + 2'(1);
   end

   ipw_startup_timer #(
      .SCALE_DIV (SUT_SCALE_DIV)
   ) u_sut (
      .i_ref_clk (i_ref_clk),
      .i_resetn  (i_resetn),
      .i_start   (tmr_start),
      .i_sel     (sut_sel),
      .o_done    (tmr_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // Power control register; hardware clear of requests on wake
   logic wake_now;
   assign wake_now = state_reg != ipw_pkg::IPW_RUN
                     && state_next == ipw_pkg::IPW_RUN;

   localparam logic [7:0] PWR_CTRL_POR  = 8'h10;
   localparam logic [7:0] PWR_CTRL_KEEP = 8'h10;
   localparam logic [7:0] PWR_CTRL_REQ  = 8'h03;   // Idle and power-down bits
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_por_n)
         pwr_ctrl_reg <= PWR_CTRL_POR;
      else if (!i_resetn)
         pwr_ctrl_reg <= pwr_ctrl_reg & PWR_CTRL_KEEP;
      else if (wake_now)
         pwr_ctrl_reg <= pwr_ctrl_reg & ~PWR_CTRL_REQ;
      else if (wr_en && hit(paddr, ipw_pkg::PWR_CTRL_ADR) && pstrb[0])
         pwr_ctrl_reg <= pwdata[7:0];
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
         wake_cfg_reg <= ipw_pkg::WAKE_CFG_RST;
      else if (wr_en && hit(paddr, ipw_pkg::WAKE_CFG_ADR))
         for (int b = 0; b < 4; b++)
            if (pstrb[b])
               wake_cfg_reg[b*8 +: 8] <= pwdata[b*8 +: 8];
   end

   ////////////////////////////////////////////////////////////////////////
   // APB answer: one wait-free access phase, read data registered in setup
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         o_prdata  <= '0;
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
      end
      else
      begin
         o_pready  <= psel && !penable;
         o_pslverr <= psel && !penable &&
                      !(hit(paddr, ipw_pkg::PWR_CTRL_ADR) ||
                        hit(paddr, ipw_pkg::WAKE_CFG_ADR) ||
                        hit(paddr, ipw_pkg::STATUS_ADR));
         if (rd_en && hit(paddr, ipw_pkg::PWR_CTRL_ADR))
            o_prdata <= {24'h0, pwr_ctrl_reg};
         else if (rd_en && hit(paddr, ipw_pkg::WAKE_CFG_ADR))
            o_prdata <= wake_cfg_reg;
         else if (rd_en && hit(paddr, ipw_pkg::STATUS_ADR))
            o_prdata <= {29'h0, state_reg};
         else if (rd_en)
            o_prdata <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock, power and hold outputs, all registered
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         o_cpu_clk_en     <= 1'b1;
         o_periph_clk_en  <= 1'b1;
         o_periph_div_en  <= 1'b0;
         o_adc_div_bypass <= 1'b1;
         o_port_hold      <= 1'b0;
         o_wdt_run        <= 1'b1;
         o_osc_en         <= 1'b1;
         o_bod_en         <= 1'b0;
         o_flash_pwr_en   <= 1'b1;
         o_ram_retain     <= 1'b1;
         o_int_reset      <= 1'b0;
         o_wake_irq       <= 1'b0;
         o_baud_doubler   <= 1'b0;
      end
      else
      begin
         o_cpu_clk_en    <= state_next == ipw_pkg::IPW_RUN;
         o_periph_clk_en <= state_next != ipw_pkg::IPW_PDOWN;
         o_periph_div_en <= i_clk_div_on;
         o_adc_div_bypass <= 1'b1;
         o_port_hold     <= state_next == ipw_pkg::IPW_IDLE;
         o_wdt_run       <= state_next == ipw_pkg::IPW_RUN ||
                            (state_next == ipw_pkg::IPW_IDLE &&
                             wake_cfg_reg[ipw_pkg::WD_IDLE_BIT]);
         o_osc_en        <= state_next != ipw_pkg::IPW_PDOWN;
         o_bod_en        <= bod_fuse &&
                            state_next != ipw_pkg::IPW_PDOWN;
         o_flash_pwr_en  <= state_next != ipw_pkg::IPW_PDOWN;
         o_ram_retain    <= 1'b1;
         o_int_reset     <= state_next == ipw_pkg::IPW_RST_HOLD ||
                            state_next == ipw_pkg::IPW_RST_SHORT;
         o_wake_irq      <= wake_now &&
                            (state_reg == ipw_pkg::IPW_WAIT_TMR ||
                             state_reg == ipw_pkg::IPW_WAIT_PIN);
         o_baud_doubler  <= pwr_ctrl_reg[ipw_pkg::BAUD_BIT];
      end
   end

endmodule

/* ipw_pkg.sv */
// Purpose: Constants shared by the idle/power-down wake controller
// Assumes: 40 MHz reference clock, APB register access
// Notes:   Power control register sits at index 0x87 (byte addr 0x21C)
package ipw_pkg;

   // Clock rate in kHz
   localparam int unsigned CLK_KHZ = 40000;

   // Register indices (byte address is four times the index)
   localparam logic [7:0]  PWR_CTRL_IDX = 8'h87;
   localparam logic [7:0]  WAKE_CFG_IDX = 8'h88;
   localparam logic [7:0]  STATUS_IDX   = 8'h89;
   localparam logic [11:0] PWR_CTRL_ADR = {2'h0, PWR_CTRL_IDX, 2'h0};
   localparam logic [11:0] WAKE_CFG_ADR = {2'h0, WAKE_CFG_IDX, 2'h0};
   localparam logic [11:0] STATUS_ADR   = {2'h0, STATUS_IDX, 2'h0};

   // Power control bit positions
   localparam int IDLE_BIT     = 0;
   localparam int PDOWN_BIT    = 1;
   localparam int UFLAG_LO_BIT = 2;
   localparam int UFLAG_HI_BIT = 3;
   localparam int COLD_BIT     = 4;
   localparam int WEXIT_BIT    = 5;
   localparam int FRAME_BIT    = 6;
   localparam int BAUD_BIT     = 7;
   localparam logic [7:0] PWR_CTRL_RST = 8'h00;
   localparam logic [7:0] PWR_CTRL_WMASK = 8'hEF;

   // Wake configuration bit positions
   localparam int EX0_EN_BIT  = 0;
   localparam int EX1_EN_BIT  = 1;
   localparam int EX0_TT_BIT  = 2;
   localparam int EX1_TT_BIT  = 3;
   localparam int GP_GRP_BIT  = 4;
   localparam int WD_IDLE_BIT = 5;
   localparam int GP_MASK_LSB = 8;
   localparam int GP_LVL_LSB  = 16;
   localparam logic [31:0] WAKE_CFG_RST = 32'h0000_0000;

   // Start-up times in microseconds, indexed {crystal, fuse[1:0]}
   localparam int unsigned SUT_US [8] =
      '{16, 512, 1024, 4096, 1024, 2048, 4096, 16384};

   // Internal reset stretch after an early reset-pin release
   localparam int unsigned SHORT_RST_CYC = 2;

   typedef enum logic [2:0] {
      IPW_RUN, IPW_IDLE, IPW_PDOWN, IPW_WAIT_TMR, IPW_WAIT_PIN,
      IPW_RST_TMR, IPW_RST_HOLD, IPW_RST_SHORT
   } ipw_state_t;

endpackage

/* ipw_startup_timer.sv */
// Purpose: Start-up timer counting the fuse-selected delay
// Assumes: Start pulse loads, done is a level until next start
// Notes:   Delay count derived from microseconds and clock rate
`timescale 1ns/100ps
module ipw_startup_timer #(
   parameter int unsigned SCALE_DIV = 1,
   parameter int unsigned CW        = 20
) (
   // Clock and reset
   input  wire logic          i_ref_clk,
   input  wire logic          i_resetn,
   // Control
   input  wire logic          i_start,
   input  wire logic [2:0]    i_sel,
   // Status
   output logic               o_done
);

   logic [CW-1:0] count_reg;

   // Cycles for a selection; scale lets a bench shorten it
   function automatic logic [CW-1:0] sut_cycles(input logic [2:0] sel);
      int unsigned cyc;
      cyc = ipw_pkg::SUT_US[sel] * (ipw_pkg::CLK_KHZ / 1000) / SCALE_DIV;
      if (cyc < 1)
         cyc = 1;
      return CW'(cyc);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Down counter, done when it reaches zero
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
         count_reg <= '0;
      else if (i_start)
         count_reg <= sut_cycles(i_sel);
      else if (count_reg != '0)
         count_reg <= count_reg - CW'(1);
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
         o_done <= 1'b0;
      else
         o_done <= !i_start && (count_reg == CW'(1) ||
                   (count_reg == '0 && o_done));
   end

endmodule

/* ipw_power_ctrl_sva.sv */
// Purpose: Port-level checks on the power sequencer
// Assumes: Sees the top-level ports only
// Notes:   Bound into every instance of the sequencer
`timescale 1ns/100ps
module ipw_power_ctrl_sva (
   // Clock, reset and bus
   input wire logic       i_ref_clk,
   input wire logic       i_resetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       o_pready,
   // Pins, fuses and clock-divider input
   input wire logic       i_ext_irq_zero_pin_n,
   input wire logic       i_ext_irq_one_pin_n,
   input wire logic [7:0] i_general_pin_irq_n,
   input wire logic       i_ext_reset_pin_n,
   input wire logic       i_bod_fuse,
   input wire logic       i_clk_div_on,
   // Power controls
   input wire logic       o_cpu_clk_en,
   input wire logic       o_periph_clk_en,
   input wire logic       o_periph_div_en,
   input wire logic       o_adc_div_bypass,
   input wire logic       o_port_hold,
   input wire logic       o_wdt_run,
   input wire logic       o_osc_en,
   input wire logic       o_bod_en,
   input wire logic       o_flash_pwr_en,
   input wire logic       o_ram_retain,
   input wire logic       o_int_reset,
   input wire logic       o_wake_irq
);
   ////////////////////////////////////////////////////////////////////////
   // All wake sources idle; six quiet cycles cover the pin synchronisers
   wire logic pins_hi;
   assign pins_hi = i_ext_irq_zero_pin_n & i_ext_irq_one_pin_n &
                    (&i_general_pin_irq_n) & i_ext_reset_pin_n;
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_resetn);
   ////////////////////////////////////////////////////////////////////////
   a_apb_answer: assert property (psel && !penable |=> o_pready ##1 !o_pready)
      else $error("pready not a single cycle after setup");
   a_bod_gate: assert property (
      $past(i_resetn) |-> o_bod_en == (i_bod_fuse && o_osc_en))
      else $error("brown-out enable wrong for state");
   a_pd_dark: assert property (!o_osc_en |-> !o_flash_pwr_en &&
      !o_periph_clk_en && !o_cpu_clk_en && o_ram_retain)
      else $error("power-down left something powered");
   a_idle_hold: assert property (o_port_hold |->
      !o_cpu_clk_en && o_periph_clk_en && o_osc_en)
      else $error("idle clocks wrong");
   a_wdt_idle: assert property (
      o_wdt_run |-> o_cpu_clk_en || o_port_hold)
      else $error("watchdog runs outside run or idle");
   a_div_mirror: assert property ($past(i_resetn) |->
      o_periph_div_en == $past(i_clk_div_on) && o_adc_div_bypass)
      else $error("divider controls wrong");
   a_wake_pulse: assert property (
      o_wake_irq |=> !o_wake_irq && o_cpu_clk_en)
      else $error("wake pulse not single or clock still gated");
   a_pd_stays: assert property (
      (!o_osc_en && pins_hi) [*6] |=> !o_osc_en)
      else $error("power-down left without a wake source");
   c_idle: cover property (o_port_hold);
   c_pdown: cover property (!o_osc_en);
   c_wake: cover property (o_wake_irq);
   c_rst: cover property ($rose(o_int_reset));
endmodule
bind ipw_power_ctrl ipw_power_ctrl_sva u_sva (.i_ref_clk(i_ref_clk),
   .i_resetn(i_resetn), .psel(psel), .penable(penable),
   .o_pready(o_pready), .i_ext_irq_zero_pin_n(i_ext_irq_zero_pin_n),
   .i_ext_irq_one_pin_n(i_ext_irq_one_pin_n),
   .i_general_pin_irq_n(i_general_pin_irq_n),
   .i_ext_reset_pin_n(i_ext_reset_pin_n), .i_bod_fuse(i_bod_fuse),
   .i_clk_div_on(i_clk_div_on), .o_cpu_clk_en(o_cpu_clk_en),
   .o_periph_clk_en(o_periph_clk_en), .o_periph_div_en(o_periph_div_en),
   .o_adc_div_bypass(o_adc_div_bypass), .o_port_hold(o_port_hold),
   .o_wdt_run(o_wdt_run), .o_osc_en(o_osc_en), .o_bod_en(o_bod_en),
   .o_flash_pwr_en(o_flash_pwr_en), .o_ram_retain(o_ram_retain),
   .o_int_reset(o_int_reset), .o_wake_irq(o_wake_irq));

/* ipw_pin_model.sv */
// Purpose: Drives one wake or reset pin low for a chosen span
// Assumes: Pins idle high through pull-ups
// Notes:   Index 0/1 external pins, 2 reset pin, 3..10 general pins
`timescale 1ns/100ps
module ipw_pin_model (
   // Clock and command
   input  wire logic        i_ref_clk,
   input  wire logic        i_go,
   input  wire logic [3:0]  i_sel,
   input  wire logic [15:0] i_len,
   // Pins
   output logic [10:0]      o_pins_n
);
   logic [15:0] cnt_reg = 16'h0000;
   logic [3:0]  sel_reg = 4'h0;
   // Span counter; loaded on go, then counts down one per clock to zero
   always_ff @(posedge i_ref_clk)
   begin
      if (i_go)
      begin
         cnt_reg <= i_len;
         sel_reg <= i_sel;
      end
      else if (cnt_reg != 16'h0000)
         cnt_reg <= cnt_reg - 16'h0001;
   end
   // Released pins go back to the pull-up level
   always_comb
   begin
      o_pins_n = 11'h7FF;
      if (cnt_reg != 16'h0000)
         o_pins_n[sel_reg] = 1'b0;
   end
endmodule

/* ipw_tb.sv */
// Purpose: Self-checking bench for the power sequencer
// Assumes: Start-up counts divided by SCALE, fuse codes 00 and 01
// Notes:   Timer is 10 cycles on RC fuse 00, 320 on RC fuse 01, 640 on crystal at this scale
`timescale 1ns/100ps
module testbench;
   localparam int unsigned SCALE = 64;
   logic        clk, rstn, porn, psel, penable, pwrite, pready, pslverr;
   logic        go, xtal, bodf, irqp, divon, cpu, pclk, pdiv, adcb, hold;
   logic        wdt, osc, brownout_detector, flash, ram, irst, wirq, baud, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb, sel;
   logic [15:0] len;
   logic [10:0] pins;
   logic [1:0]  fuse;
   int          failures, comparisons;
   ////////////////////////////////////////////////////////////////////////
   ipw_power_ctrl #(.SUT_SCALE_DIV(SCALE)) DUT (.i_ref_clk(clk),
      .i_resetn(rstn), .i_por_n(porn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_ext_irq_zero_pin_n(pins[0]), .i_ext_irq_one_pin_n(pins[1]),
      .i_general_pin_irq_n(pins[10:3]), .i_ext_reset_pin_n(pins[2]),
      .i_sut_fuse(fuse), .i_crystal_src(xtal), .i_bod_fuse(bodf),
      .i_irq_pending(irqp), .i_clk_div_on(divon), .o_cpu_clk_en(cpu),
      .o_periph_clk_en(pclk), .o_periph_div_en(pdiv),
      .o_adc_div_bypass(adcb), .o_port_hold(hold), .o_wdt_run(wdt),
      .o_osc_en(osc), .o_bod_en(brownout_detector), .o_flash_pwr_en(flash),
      .o_ram_retain(ram), .o_int_reset(irst), .o_wake_irq(wirq),
      .o_baud_doubler(baud));
   ipw_pin_model PM (.i_ref_clk(clk), .i_go(go), .i_sel(sel), .i_len(len),
      .o_pins_n(pins));
   // Free-running 40 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, g);
      comparisons++;
      if (g !== e)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Bus cycle; held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input int d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      chk("pready", 1, pready);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic pin(input logic [3:0] s, input logic [15:0] l);
      go <= 1'b1;
      sel <= s;
      len <= l;
      @(posedge clk);
      go <= 1'b0;
   endtask
   task automatic wait_cpu(output int n);
      n = 0;
      while (cpu !== 1'b1 && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic warm();
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
   endtask
   // Enter power-down and check what must be switched off
   task automatic pd_enter(input int wc, input int pc);
      apb(1'b1, ipw_pkg::WAKE_CFG_ADR, wc);
      apb(1'b1, ipw_pkg::PWR_CTRL_ADR, pc);
      repeat (3) @(posedge clk);
      chk("osc_en", 0, osc);
      chk("bod_en", 0, brownout_detector);
      chk("flash_en", 0, flash);
      chk("ram_retain", 1, ram);
      chk("hold_pd", 0, hold);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      apb(1'b0, ipw_pkg::PWR_CTRL_ADR, 0);
      chk("power_control_por", 32'h10, rd);
      apb(1'b1, ipw_pkg::PWR_CTRL_ADR, 32'hDC);
      apb(1'b0, ipw_pkg::PWR_CTRL_ADR, 0);
      chk("power_control_wr", 32'hDC, rd);
      chk("baud", 1, baud);
      warm();
      apb(1'b0, ipw_pkg::PWR_CTRL_ADR, 0);
      chk("power_control_warm1", 32'h10, rd);
      apb(1'b1, ipw_pkg::PWR_CTRL_ADR, 0);
      warm();
      apb(1'b0, ipw_pkg::PWR_CTRL_ADR, 0);
      chk("power_control_warm0", 32'h00, rd);
      apb(1'b0, 12'h3F0, 0);
      chk("unmapped_err", 1, err);
      divon <= 1'b1;
      repeat (2) @(posedge clk);
      chk("div_en", 1, pdiv);
      chk("adc_bypass", 1, adcb);
      divon <= 1'b0;
      $display("t_regs done");
   endtask
   task automatic t_idle();
      int n;
      for (int k = 0; k < 2; k++)
      begin
         apb(1'b1, ipw_pkg::WAKE_CFG_ADR, k << 5);
         apb(1'b1, ipw_pkg::PWR_CTRL_ADR, 32'h01);
         repeat (2) @(posedge clk);
         chk("cpu_idle", 0, cpu);
         chk("periph_idle", 1, pclk);
         chk("port_hold", 1, hold);
         chk("wdt_idle", k, wdt);
         chk("bod_idle", 1, brownout_detector);
         irqp <= 1'b1;
         @(posedge clk);
         irqp <= 1'b0;
         wait_cpu(n);
         chk("idle_exit", 1, n < 6);
         apb(1'b0, ipw_pkg::PWR_CTRL_ADR, 0);
         chk("idle_clr", 0, rd);
      end
      $display("t_idle done");
   endtask
   // Timed wake on both clock sources; pin rises long before timeout
   task automatic t_timed();
      int n;
      int lo;
      for (int x = 0; x < 3; x++)
      begin
         xtal <= x[0];
         fuse <= x[1] ? 2'b01 : 2'b00;
         lo = (x == 2) ? 320 : (x ? 640 : 10);
         pd_enter(32'h01, 32'h03);
         pin(4'd0, 16'd3);
         wait_cpu(n);
         chk("timed", 1, n >= lo && n <= lo + 14);
         chk("wake_irq", 1, wirq);
         apb(1'b0, ipw_pkg::PWR_CTRL_ADR, 0);
         chk("pd_clr", 0, rd);
      end
      xtal <= 1'b0;
      fuse <= 2'b00;
      $display("t_timed done");
   endtask
   task automatic t_pinctl();
      int n;
      pd_enter(32'h01, 32'h22);
      pin(4'd0, 16'd60);
      wait_cpu(n);
      chk("pin_ctl", 1, n >= 60 && n <= 70);
      apb(1'b0, ipw_pkg::PWR_CTRL_ADR, 0);
      chk("pd_clr_ext", 32'h20, rd);
      $display("t_pinctl done");
   endtask
   task automatic t_gp();
      int n;
      pd_enter(32'h0004_0410, 32'h02);
      pin(4'd5, 16'd3);
      wait_cpu(n);
      chk("gp_wake", 1, n >= 10 && n <= 24);
      $display("t_gp done");
   endtask
   // Edge-typed and group-disabled pins must not wake; short reset does
   task automatic t_gate();
      int n;
      int c;
      pd_enter(32'h0004_040A, 32'h02);
      pin(4'd1, 16'd3);
      repeat (5) @(posedge clk);
      pin(4'd5, 16'd3);
      repeat (40) @(posedge clk);
      chk("no_wake", 0, cpu);
      pin(4'd2, 16'd3);
      n = 0;
      c = 0;
      while (irst !== 1'b1 && n < 100)
      begin
         @(posedge clk);
         n++;
      end
      while (irst === 1'b1 && c < 50)
      begin
         @(posedge clk);
         c++;
      end
      chk("short_rst", 2, c);
      $display("t_gate done");
   endtask
   task automatic t_rstlong();
      int n;
      pd_enter(32'h01, 32'h02);
      pin(4'd2, 16'd40);
      n = 0;
      while (irst !== 1'b1 && n < 100)
      begin
         @(posedge clk);
         n++;
      end
      chk("rst_early", 1, n < 40);
      while (irst === 1'b1 && n < 100)
      begin
         @(posedge clk);
         n++;
      end
      chk("rst_hold", 1, n >= 40 && n <= 48);
      $display("t_rstlong done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Watchdog against a hung wait; tests take well under two thousand cycles
   initial
   begin
      #500000;
      failures++;
      $display("unexpected timeout expected done seen hang");
      final_report();
   end
   initial
   begin
      failures = 0;
      comparisons = 0;
      {rstn, porn, psel, penable, pwrite, go, xtal, irqp, divon} = 9'h000;
      {paddr, pwdata, sel, len, fuse} = 66'h0;
      pstrb = 4'hF;
      bodf = 1'b1;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      porn <= 1'b1;
      t_regs();
      t_idle();
      t_timed();
      t_pinctl();
      t_gp();
      t_gate();
      t_rstlong();
      final_report();
   end
endmodule
